/* File: inc/higher_branch_pkg.sv */
package higher_branch_pkg;

    // ------------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------------
    localparam logic [7:0]  OPCODE_HIGHER       = 8'h22;
    localparam logic [15:0] PC_STEP             = 16'h0002;
    localparam logic [15:0] PC_RESET            = 16'h0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam logic [1:0]  TAKEN_FETCHES       = 2'h3;
    localparam logic [1:0]  NOT_TAKEN_FETCHES   = 2'h1;

    // ------------------------------------------------------------------
    // Condition code bit positions (S X H I N Z V C)
    // ------------------------------------------------------------------
    localparam int          CCR_C_BIT           = 0;
    localparam int          CCR_Z_BIT           = 2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH
    } branch_state_t;

endpackage

/* File: logic/higher_condition.sv */
`timescale 1ns/100ps
module higher_condition (
    input  wire logic [7:0] ccr_in,
    output logic            taken_out
);
    import higher_branch_pkg::*;

    // Carry clear and zero clear means the register operand was strictly
    // higher as an unsigned number, for both register-memory and the
    // accumulator-to-accumulator compare or subtract.
    assign taken_out = ~(ccr_in[CCR_C_BIT] | ccr_in[CCR_Z_BIT]);
endmodule // higher_condition

/* File: logic/unsigned_higher_branch_unit.sv */
`timescale 1ns/100ps
module unsigned_higher_branch_unit (
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        issue_in,
    input  wire logic [7:0]                  opcode_in,
    input  wire logic [7:0]                  short_displacement_in,
    input  wire logic [15:0]                 pc_in,
    input  wire logic [7:0]                  ccr_in,
    output logic                             busy_out,
    output logic                             done_out,
    output logic                             taken_out,
    output logic                             fetch_out,
    output logic [15:0]                      fetch_addr_out,
    output logic                             pc_load_out,
    output logic [15:0]                      pc_out,
    output logic [7:0]                       ccr_out
);
    import higher_branch_pkg::*;

    // ------------------------------------------------------------------
    // Decode and condition
    // ------------------------------------------------------------------
    logic          hit;
    logic          cond_taken;
    logic [15:0]   target;
    branch_state_t state_ff;
    logic [1:0]    left_ff;
    logic          taken_ff;
    logic [15:0]   addr_ff;

    assign hit = issue_in && (state_ff == ST_IDLE) && (opcode_in == OPCODE_HIGHER);

    higher_condition u_cond (
        .ccr_in    (ccr_in),
        .taken_out (cond_taken)
    );

    // Sign extension lets backward branches wrap correctly modulo 64K.
    assign target = 16'(pc_in + PC_STEP + {{8{short_displacement_in[7]}}, short_displacement_in});

    // ------------------------------------------------------------------
    // Fetch sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            left_ff  <= 2'h0;
            taken_ff <= 1'b0;
            addr_ff  <= PC_RESET;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (hit) begin
                        state_ff <= ST_FETCH;
                        taken_ff <= cond_taken;
                        left_ff  <= cond_taken ? TAKEN_FETCHES : NOT_TAKEN_FETCHES;
                        addr_ff  <= cond_taken ? target : 16'(pc_in + PC_STEP);
                    end
                end
                default: begin
                    left_ff <= 2'(left_ff - 2'h1);
                    addr_ff <= 16'(addr_ff + 16'h0001);
                    if (left_ff == 2'h1) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_out       <= 1'b0;
            fetch_out      <= 1'b0;
            fetch_addr_out <= PC_RESET;
            done_out       <= 1'b0;
            taken_out      <= 1'b0;
        end else begin
            busy_out       <= hit || (state_ff == ST_FETCH && left_ff != 2'h1);
            fetch_out      <= (state_ff == ST_FETCH);
            fetch_addr_out <= addr_ff;
            done_out       <= (state_ff == ST_FETCH) && (left_ff == 2'h1);
            taken_out      <= (state_ff == ST_FETCH) && (left_ff == 2'h1) && taken_ff;
        end
    end

    // A taken branch loads the PC once at decision time so the core redirects early;
    // flags pass back untouched because this instruction never alters them.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pc_load_out <= 1'b0;
            pc_out      <= PC_RESET;
            ccr_out     <= 8'h00;
        end else begin
            pc_load_out <= hit && cond_taken;
            if (hit) begin
                pc_out  <= cond_taken ? target : 16'(pc_in + PC_STEP);
                ccr_out <= ccr_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_taken_issue;
        hit && cond_taken;
    endsequence

    sequence s_three_fetches;
        fetch_out [*3] ##1 !fetch_out;
    endsequence

    property p_taken_fetch;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_taken_issue |-> ##2 s_three_fetches;
    endproperty
    a_taken_fetch: assert property (p_taken_fetch) else $error("taken branch fetch count wrong");

    property p_not_taken_fetch;
        @(posedge clk_in) disable iff (!rst_n_in)
        (hit && !cond_taken) |-> ##2 fetch_out ##1 !fetch_out;
    endproperty
    a_not_taken_fetch: assert property (p_not_taken_fetch) else $error("not taken fetch count wrong");

    property p_condition;
        @(posedge clk_in) disable iff (!rst_n_in)
        hit |-> ##1 (pc_load_out == !($past(ccr_in[CCR_C_BIT]) || $past(ccr_in[CCR_Z_BIT])));
    endproperty
    a_condition: assert property (p_condition) else $error("branch condition wrong");

    property p_target;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_taken_issue |-> ##2 (fetch_addr_out == pc_out);
    endproperty
    a_target: assert property (p_target) else $error("first fetch not at target");

    property p_unsigned;
        @(posedge clk_in) disable iff (!rst_n_in)
        (hit && ccr_in[CCR_C_BIT]) |-> ##1 !pc_load_out;
    endproperty
    a_unsigned: assert property (p_unsigned) else $error("taken with carry set");

    property p_accum;
        @(posedge clk_in) disable iff (!rst_n_in)
        (hit && ccr_in[CCR_Z_BIT]) |-> ##1 (pc_out == $past(pc_in) + PC_STEP);
    endproperty
    a_accum: assert property (p_accum) else $error("taken on equal operands");

    property p_flags;
        @(posedge clk_in) disable iff (!rst_n_in)
        hit |-> ##1 (ccr_out == $past(ccr_in));
    endproperty
    a_flags: assert property (p_flags) else $error("flags changed");

    property p_done;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_taken_issue |-> ##4 (done_out && taken_out);
    endproperty
    a_done: assert property (p_done) else $error("done not reported");

    // ------------------------------------------------------------------
    // Sequencing checks
    // ------------------------------------------------------------------
    // A fall-through still makes its single fetch, so the core keeps the
    // queue fed from pc plus two without a separate path.
    sequence s_not_taken_issue;
        hit && !cond_taken;
    endsequence

    property p_ignore_other;
        @(posedge clk_in) disable iff (!rst_n_in)
        (issue_in && (state_ff == ST_IDLE) && (opcode_in != OPCODE_HIGHER)) |-> ##1 !busy_out;
    endproperty
    a_ignore_other: assert property (p_ignore_other) else $error("foreign opcode accepted");

    property p_fetch_step;
        @(posedge clk_in) disable iff (!rst_n_in)
        (fetch_out && $past(fetch_out)) |-> (fetch_addr_out == 16'($past(fetch_addr_out) + 16'h0001));
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("fetch address not sequential");

    property p_busy_span;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_taken_issue |-> ##1 busy_out [*3] ##1 !busy_out;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("taken busy span wrong");

    property p_not_taken_done;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_not_taken_issue |-> ##2 (done_out && !taken_out);
    endproperty
    a_not_taken_done: assert property (p_not_taken_done) else $error("fall-through not reported");

    property p_fall_through;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_not_taken_issue |-> ##1 (pc_out == 16'($past(pc_in) + PC_STEP)) ##1 (fetch_addr_out == pc_out);
    endproperty
    a_fall_through: assert property (p_fall_through) else $error("fall-through address wrong");

    property p_taken_sum;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_taken_issue |-> ##1 (pc_out == 16'($past(pc_in) + PC_STEP
            + {{8{$past(short_displacement_in[7])}}, $past(short_displacement_in)}));
    endproperty
    a_taken_sum: assert property (p_taken_sum) else $error("taken target sum wrong");

    property p_load_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
        pc_load_out |=> !pc_load_out;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("pc load held too long");

    property p_done_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
        done_out |=> !done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
endmodule // unsigned_higher_branch_unit

/* File: testbench/unsigned_higher_branch_unit_tb.sv */
`timescale 1ns/100ps
module unsigned_higher_branch_unit_tb;
    import higher_branch_pkg::*;
    typedef struct {logic tk; logic [15:0] pc; logic [7:0] ccr; int n;} note_t;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, issue_in = 1'b0;
    logic [7:0]  opcode_in = 8'h00, short_displacement_in = 8'h00, ccr_in = 8'h00;
    logic [15:0] pc_in = 16'h0000, fetch_addr_out, pc_out, fa0;
    logic        busy_out, done_out, taken_out, fetch_out, pc_load_out, pl = 1'b0;
    logic [7:0]  ccr_out;
    int          mismatches = 0, cmp_count = 0, nf = 0;
    note_t       q[$];
    note_t       e;
    unsigned_higher_branch_unit u_unsigned_higher_branch_unit (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .issue_in(issue_in), .opcode_in(opcode_in),
        .short_displacement_in(short_displacement_in), .pc_in(pc_in), .ccr_in(ccr_in),
        .busy_out(busy_out), .done_out(done_out), .taken_out(taken_out), .fetch_out(fetch_out),
        .fetch_addr_out(fetch_addr_out), .pc_load_out(pc_load_out), .pc_out(pc_out), .ccr_out(ccr_out));
    always #2.5 clk_in = ~clk_in;
    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Fetches must walk upward from the first address without gaps.
    always @(posedge clk_in) if (rst_n_in) begin
        if (pc_load_out === 1'b1) pl = 1'b1;
        if (fetch_out === 1'b1) begin
            if (nf == 0) fa0 = fetch_addr_out;
            else chk(fetch_addr_out, fa0 + 16'(nf));
            nf++;
        end
        if (done_out === 1'b1) begin
            chk(16'(busy_out), 16'h0000);
            if (q.size() == 0) chk(16'h0001, 16'h0000);
            else begin
                e = q.pop_front();
                chk(16'(taken_out), 16'(e.tk));
                chk(16'(pl), 16'(e.tk));
                chk(pc_out, e.pc);
                chk(16'(ccr_out), 16'(e.ccr));
                chk(fa0, e.pc);
                chk(16'(nf), 16'(e.n));
            end
            nf = 0;
            pl = 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    task go(input logic [7:0] op, input logic [7:0] d, input logic [15:0] pc, input logic [7:0] f);
        int    i;
        note_t x;
        x.tk  = !(f[CCR_C_BIT] | f[CCR_Z_BIT]);
        x.pc  = x.tk ? pc + PC_STEP + {{8{d[7]}}, d} : pc + PC_STEP;
        x.ccr = f;
        x.n   = x.tk ? int'(TAKEN_FETCHES) : int'(NOT_TAKEN_FETCHES);
        @(posedge clk_in);
        if (op == OPCODE_HIGHER) q.push_back(x);
        issue_in <= 1'b1;
        opcode_in <= op;
        short_displacement_in <= d;
        pc_in <= pc;
        ccr_in <= f;
        @(posedge clk_in);
        issue_in <= 1'b0;
        @(negedge clk_in);
        if (op == OPCODE_HIGHER) chk(16'(busy_out), 16'h0001);
        for (i = 0; i < 12 && done_out !== 1'b1; i++) @(negedge clk_in);
        if (op != OPCODE_HIGHER) begin
            chk(16'(i), 16'h000C);
            chk(16'(busy_out), 16'h0000);
        end else if (i == 12) chk(16'(done_out), 16'h0001);
    endtask
    initial begin
        logic [15:0] a, b;
        logic [7:0]  f;
        void'($urandom(96));
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            f = 8'($urandom);
            f[CCR_C_BIT] = k[0];
            f[CCR_Z_BIT] = k[1];
            go(OPCODE_HIGHER, 8'($urandom), 16'($urandom), f);
        end
        go(OPCODE_HIGHER, 8'h80, 16'h0010, 8'h00);
        go(OPCODE_HIGHER, 8'h7F, 16'hFFF0, 8'h00);
        go(OPCODE_HIGHER, 8'hFE, 16'h0000, 8'h00);
        // Flags come from an unsigned subtract of register minus operand.
        for (int k = 0; k < 8; k++) begin
            a = 16'($urandom);
            b = (k < 2) ? a : 16'($urandom);
            f = 8'($urandom);
            f[CCR_C_BIT] = a < b;
            f[CCR_Z_BIT] = a == b;
            go(OPCODE_HIGHER, 8'($urandom), 16'($urandom), f);
            chk(16'(taken_out), 16'(a > b));
        end
        go(8'h23, 8'h10, 16'h1000, 8'h00);
        go(8'h24, 8'h10, 16'h1000, 8'h00);
        go(OPCODE_HIGHER, 8'h04, 16'h2000, 8'h00);
        repeat (4) @(posedge clk_in);
        chk(16'(q.size()), 16'h0000);
        conclude;
    end
    initial begin
        #20000;
        mismatches++;
        conclude;
    end
endmodule // unsigned_higher_branch_unit_tb
